// ---- hw/port_pkg.sv ----
// Constants and register map of the general-purpose port block
package port_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_OUT_LATCH   = 8'h00;
  localparam logic [7:0] ADDR_PIN_INPUT   = 8'h04;
  localparam logic [7:0] ADDR_DIRECTION   = 8'h08;
  localparam logic [7:0] ADDR_RED_DRIVE   = 8'h0C;
  localparam logic [7:0] ADDR_PULL_EN     = 8'h10;
  localparam logic [7:0] ADDR_PULL_POL    = 8'h14;
  localparam logic [7:0] ADDR_WIRED_OR    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN      = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_FLAG    = 8'h20;
  localparam logic [7:0] ADDR_ROUTING     = 8'h24;
  localparam logic [7:0] ADDR_HV_DIG_EN   = 8'h28;
  localparam logic [7:0] ADDR_HV_ANA_EN   = 8'h2C;
  localparam logic [7:0] ADDR_HV_INPUT    = 8'h30;
  localparam logic [7:0] ADDR_HV_FLAGS    = 8'h34;
  localparam logic [7:0] ADDR_HV_IRQ_EN   = 8'h38;
  localparam logic [7:0] ADDR_HV_POL      = 8'h3C;
  localparam logic [7:0] ADDR_EXT_IRQ_CTL = 8'h40;
  // Field positions
  localparam int EXT_IRQ_ENABLE_POS = 6;
  localparam int ROUTE_DRV_POS      = 0;
  localparam int ROUTE_PWM_POS      = 8;
  localparam int ROUTE_TEST_POS     = 16;
  // Reset values
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // Edge filter sample count
  localparam int FILTER_SAMPLES = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : port_pkg

// ---- hw/port_pin_io.sv ----
// General-purpose port with edge flags behind an AXI4-Lite slave
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module port_pin_io #(
  parameter int WIDTH    = 6,
  parameter int HV_WIDTH = 4
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [WIDTH-1:0]    pin_in,
  output logic [WIDTH-1:0]         pin_out,
  output logic [WIDTH-1:0]         pin_oe,
  output logic [WIDTH-1:0]         pin_reduced_drive,
  output logic [WIDTH-1:0]         pin_pull_up,
  output logic [WIDTH-1:0]         pin_pull_down,
  input  wire logic [WIDTH-1:0]    periph_own,
  input  wire logic [WIDTH-1:0]    periph_out,
  input  wire logic [WIDTH-1:0]    periph_oe,
  input  wire logic [HV_WIDTH-1:0] hv_pin_in,
  output logic [HV_WIDTH-1:0]      hv_input_buffer_en,
  output logic                     port_irq,
  output logic                     hv_irq,
  output logic                     ext_irq_enable,
  output logic [23:0]              signal_routing_select
);
  initial begin
    if (WIDTH < 1 || WIDTH > 32) $error("WIDTH must be 1..32");
    if (HV_WIDTH < 1 || HV_WIDTH > 32) $error("HV_WIDTH must be 1..32");
  end

  localparam int FS = port_pkg::FILTER_SAMPLES;

  // Configuration registers
  logic [WIDTH-1:0]    latch_q, dir_q, rdr_q, per_q, pps_q, wom_q, pie_q;
  logic [WIDTH-1:0]    pif_q;
  logic [HV_WIDTH-1:0] hv_dien_q, hv_pie_q, hv_pps_q, hv_pif_q;
  logic                hv_ana_q;
  logic                irq_en_q;
  logic [23:0]         route_q;
  // Two-stage input synchronizers
  logic [WIDTH-1:0]    sync1_q, sync2_q;
  logic [HV_WIDTH-1:0] hv_sync1_q, hv_sync2_q;

  // Saturating count of samples held at one level, per pin
  function automatic logic [2:0] bump(input logic [2:0] c);
    return (c >= 3'(FS)) ? c : c + 3'h1;
  endfunction

  // Synchronizers: stage one read only by stage two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      hv_sync1_q <= '0;
      hv_sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q    <= pin_in;
      sync2_q    <= sync1_q;
      hv_sync1_q <= hv_pin_in;
      hv_sync2_q <= hv_sync1_q;
    end
  end

  // High-voltage digital mode gating
  wire [HV_WIDTH-1:0] hv_digital = hv_dien_q & {HV_WIDTH{~hv_ana_q}};
  wire [HV_WIDTH-1:0] hv_level   = hv_sync2_q & hv_digital;

  // Glitch filter: passive then active run lengths
  logic [2:0]       pas_q [WIDTH];
  logic [2:0]       act_q [WIDTH];
  logic [WIDTH-1:0] edge_det;
  logic [2:0]       hpas_q [HV_WIDTH];
  logic [2:0]       hact_q [HV_WIDTH];
  logic [HV_WIDTH-1:0] hv_edge_det;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_filt
      // Active level is high when polarity is one
      wire active = (sync2_q[g] == pps_q[g]);
      assign edge_det[g] = active && pas_q[g] == 3'(FS)
                           && act_q[g] == 3'(FS-1);
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pas_q[g] <= '0;
          act_q[g] <= '0;
        end else if (clk_en) begin
          if (!active) begin
            pas_q[g] <= (act_q[g] != 3'h0) ? 3'h1 : bump(pas_q[g]);
            act_q[g] <= '0;
          end else if (pas_q[g] == 3'(FS)) begin
            act_q[g] <= bump(act_q[g]);
            if (act_q[g] == 3'(FS-1)) pas_q[g] <= '0;
          end else begin
            pas_q[g] <= '0; // Restart sampler
            act_q[g] <= '0;
          end
        end
      end
    end
    for (g = 0; g < HV_WIDTH; g++) begin : g_hfilt
      wire active = (hv_level[g] == hv_pps_q[g]) && hv_digital[g];
      wire passive = (hv_level[g] != hv_pps_q[g]) && hv_digital[g];
      assign hv_edge_det[g] = active && hpas_q[g] == 3'(FS)
                              && hact_q[g] == 3'(FS-1);
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          hpas_q[g] <= '0;
          hact_q[g] <= '0;
        end else if (clk_en) begin
          if (passive) begin
            hpas_q[g] <= (hact_q[g] != 3'h0) ? 3'h1 : bump(hpas_q[g]);
            hact_q[g] <= '0;
          end else if (active && hpas_q[g] == 3'(FS)) begin
            hact_q[g] <= bump(hact_q[g]);
            if (hact_q[g] == 3'(FS-1)) hpas_q[g] <= '0;
          end else begin
            hpas_q[g] <= '0;
            hact_q[g] <= '0;
          end
        end
      end
    end
  endgenerate

  // AXI write channel capture, either order
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        aw_have_q, w_have_q;
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [7:0] wa = awaddr_q;
  wire wr_latch = wr_fire && wa == port_pkg::ADDR_OUT_LATCH;
  wire wr_dir   = wr_fire && wa == port_pkg::ADDR_DIRECTION;
  wire wr_rdr   = wr_fire && wa == port_pkg::ADDR_RED_DRIVE;
  wire wr_per   = wr_fire && wa == port_pkg::ADDR_PULL_EN;
  wire wr_pps   = wr_fire && wa == port_pkg::ADDR_PULL_POL;
  wire wr_wom   = wr_fire && wa == port_pkg::ADDR_WIRED_OR;
  wire wr_pie   = wr_fire && wa == port_pkg::ADDR_IRQ_EN;
  wire wr_pif   = wr_fire && wa == port_pkg::ADDR_IRQ_FLAG;
  wire wr_route = wr_fire && wa == port_pkg::ADDR_ROUTING;
  wire wr_hdien = wr_fire && wa == port_pkg::ADDR_HV_DIG_EN;
  wire wr_hana  = wr_fire && wa == port_pkg::ADDR_HV_ANA_EN;
  wire wr_hpif  = wr_fire && wa == port_pkg::ADDR_HV_FLAGS;
  wire wr_hpie  = wr_fire && wa == port_pkg::ADDR_HV_IRQ_EN;
  wire wr_hpps  = wr_fire && wa == port_pkg::ADDR_HV_POL;
  wire wr_ext   = wr_fire && wa == port_pkg::ADDR_EXT_IRQ_CTL;
  // Input registers are read-only: writes answered with error
  wire wr_known = wr_latch | wr_dir | wr_rdr | wr_per | wr_pps | wr_wom
                | wr_pie | wr_pif | wr_route | wr_hdien | wr_hana
                | wr_hpif | wr_hpie | wr_hpps | wr_ext;
  wire [WIDTH-1:0]    wd  = wdata_q[WIDTH-1:0];
  wire [HV_WIDTH-1:0] hwd = wdata_q[HV_WIDTH-1:0];

  // Write handshake and response
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= port_pkg::RESET_ZERO;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= port_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_q && !aw_take;
      s_axi_wready  <= !w_have_q && !w_take;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? port_pkg::RESP_OKAY
                                 : port_pkg::RESP_SLVERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration writes accepted at any time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_q   <= '0;
      dir_q     <= '0;
      rdr_q     <= '0;
      per_q     <= '0;
      pps_q     <= '0;
      wom_q     <= '0;
      pie_q     <= '0;
      route_q   <= '0;
      hv_dien_q <= '0;
      hv_ana_q  <= 1'b0;
      hv_pie_q  <= '0;
      hv_pps_q  <= '0;
      irq_en_q  <= 1'b0; // External interrupt inhibited at reset
    end else if (clk_en) begin
      if (wr_latch) latch_q   <= wd;
      if (wr_dir)   dir_q     <= wd;
      if (wr_rdr)   rdr_q     <= wd;
      if (wr_per)   per_q     <= wd;
      if (wr_pps)   pps_q     <= wd;
      if (wr_wom)   wom_q     <= wd;
      if (wr_pie)   pie_q     <= wd;
      if (wr_route) route_q   <= wdata_q[23:0];
      if (wr_hdien) hv_dien_q <= hwd;
      if (wr_hana)  hv_ana_q  <= wdata_q[0];
      if (wr_hpie)  hv_pie_q  <= hwd;
      if (wr_hpps)  hv_pps_q  <= hwd;
      if (wr_ext)   irq_en_q  <= wdata_q[port_pkg::EXT_IRQ_ENABLE_POS];
    end
  end

  // Flags: write one clears, new edge wins over clear
  wire [WIDTH-1:0]    pif_clr  = wr_pif  ? wd  : '0;
  wire [HV_WIDTH-1:0] hpif_clr = wr_hpif ? hwd : '0;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pif_q    <= '0;
      hv_pif_q <= '0;
    end else if (clk_en) begin
      pif_q    <= (pif_q & ~pif_clr) | edge_det;
      hv_pif_q <= (hv_pif_q & ~hpif_clr) | (hv_edge_det & hv_pie_q);
    end
  end

  // Pin drive: peripheral overrides direction
  wire [WIDTH-1:0] drv_oe  = (periph_own & periph_oe) | (~periph_own & dir_q);
  wire [WIDTH-1:0] drv_val = (periph_own & periph_out) | (~periph_own & latch_q);
  // Wired-or: drive only low levels
  wire [WIDTH-1:0] pin_oe_d = drv_oe & ~(wom_q & drv_val);
  wire [WIDTH-1:0] push_pull = drv_oe & ~wom_q;
  // Pull only for input or wired-or output
  wire [WIDTH-1:0] pull_ok   = per_q & ~push_pull;
  wire [WIDTH-1:0] pull_up_d = pull_ok & (~pps_q | (drv_oe & wom_q));
  wire [WIDTH-1:0] pull_dn_d = pull_ok & pps_q & ~drv_oe;

  // Read decode: direction selects data source
  wire [WIDTH-1:0] data_rd = (dir_q & latch_q) | (~dir_q & sync2_q);
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      port_pkg::ADDR_OUT_LATCH:   rd_word[WIDTH-1:0] = data_rd;
      port_pkg::ADDR_PIN_INPUT:   rd_word[WIDTH-1:0] = sync2_q;
      port_pkg::ADDR_DIRECTION:   rd_word[WIDTH-1:0] = dir_q;
      port_pkg::ADDR_RED_DRIVE:   rd_word[WIDTH-1:0] = rdr_q;
      port_pkg::ADDR_PULL_EN:     rd_word[WIDTH-1:0] = per_q;
      port_pkg::ADDR_PULL_POL:    rd_word[WIDTH-1:0] = pps_q;
      port_pkg::ADDR_WIRED_OR:    rd_word[WIDTH-1:0] = wom_q;
      port_pkg::ADDR_IRQ_EN:      rd_word[WIDTH-1:0] = pie_q;
      port_pkg::ADDR_IRQ_FLAG:    rd_word[WIDTH-1:0] = pif_q;
      port_pkg::ADDR_ROUTING:     rd_word[23:0] = route_q;
      port_pkg::ADDR_HV_DIG_EN:   rd_word[HV_WIDTH-1:0] = hv_dien_q;
      port_pkg::ADDR_HV_ANA_EN:   rd_word[0] = hv_ana_q;
      port_pkg::ADDR_HV_INPUT:    rd_word[HV_WIDTH-1:0] = hv_level;
      port_pkg::ADDR_HV_FLAGS:    rd_word[HV_WIDTH-1:0] = hv_pif_q;
      port_pkg::ADDR_HV_IRQ_EN:   rd_word[HV_WIDTH-1:0] = hv_pie_q;
      port_pkg::ADDR_HV_POL:      rd_word[HV_WIDTH-1:0] = hv_pps_q;
      port_pkg::ADDR_EXT_IRQ_CTL:
        rd_word[port_pkg::EXT_IRQ_ENABLE_POS] = irq_en_q;
      default:                    rd_ok = 1'b0;
    endcase
  end

  // Read channel
  wire ar_take = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= port_pkg::RESET_ZERO;
      s_axi_rresp   <= port_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? port_pkg::RESP_OKAY : port_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Registered pin controls and requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out               <= '0;
      pin_oe                <= '0; // Every pin undriven at reset
      pin_reduced_drive     <= '0;
      pin_pull_up           <= '0;
      pin_pull_down         <= '0;
      hv_input_buffer_en    <= '0;
      port_irq              <= 1'b0;
      hv_irq                <= 1'b0;
      ext_irq_enable        <= 1'b0;
      signal_routing_select <= '0;
    end else if (clk_en) begin
      pin_out               <= drv_val & ~wom_q;
      pin_oe                <= pin_oe_d;
      pin_reduced_drive     <= rdr_q & drv_oe;
      pin_pull_up           <= pull_up_d;
      pin_pull_down         <= pull_dn_d;
      hv_input_buffer_en    <= hv_digital;
      port_irq              <= |(pif_q & pie_q);
      hv_irq                <= |(hv_pif_q & hv_pie_q);
      ext_irq_enable        <= irq_en_q;
      signal_routing_select <= route_q;
    end
  end
endmodule : port_pin_io
`default_nettype wire

// ---- test/port_pin_io_chk.sv ----
// Assertion checker for the general-purpose port block
`timescale 1ns/1ps
`default_nettype none
module port_pin_io_chk #(
  parameter int WIDTH    = 6,
  parameter int HV_WIDTH = 4
) (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [WIDTH-1:0]    pin_out,
  input wire logic [WIDTH-1:0]    pin_oe,
  input wire logic [WIDTH-1:0]    pin_pull_up,
  input wire logic [WIDTH-1:0]    pin_pull_down,
  input wire logic [WIDTH-1:0]    periph_own,
  input wire logic [WIDTH-1:0]    periph_oe,
  input wire logic [HV_WIDTH-1:0] hv_input_buffer_en,
  input wire logic                port_irq,
  input wire logic                hv_irq,
  input wire logic                ext_irq_enable,
  input wire logic [23:0]         signal_routing_select
);
  logic [3:0] wr_age_q;
  logic [3:0] wr_age_d;
  // Cycles since the last write address or reset, saturating
  assign wr_age_d = (s_axi_awvalid && s_axi_awready) ? 4'h0 :
                    (wr_age_q == 4'hF) ? wr_age_q : wr_age_q + 4'h1;
  always_ff @(posedge clk) begin
    if (sys_rst) wr_age_q <= 4'h0; // Reset also changes outputs
    else wr_age_q <= wr_age_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Software-caused changes follow a write within a few cycles
  sequence wr_recent;
    wr_age_q <= 4'h6;
  endsequence
  pull_exclusive_a: assert property (
    (pin_pull_up & pin_pull_down) == '0) else $error("both pulls on");
  push_pull_a: assert property (
    ((pin_oe & pin_out) & (pin_pull_up | pin_pull_down)) == '0)
    else $error("pull on a push-pull output");
  own_drive_a: assert property ($stable(periph_own & ~periph_oe) |=>
    (pin_oe & $past(periph_own & ~periph_oe)) == '0)
    else $error("owned pin driven without peripheral enable");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer lost");
  irq_fall_a: assert property (
    $fell(port_irq) || $fell(hv_irq) |-> wr_recent)
    else $error("request dropped without a write");
  hv_buffer_a: assert property (
    !$stable(hv_input_buffer_en) |-> wr_recent)
    else $error("input buffer changed without a write");
  ext_enable_a: assert property (
    !$stable(ext_irq_enable) |-> wr_recent)
    else $error("external enable changed without a write");
  route_copy_a: assert property (
    !$stable(signal_routing_select) |-> wr_recent)
    else $error("routing changed without a write");
  reset_clear_a: assert property (disable iff (1'b0)
    sys_rst |=> !ext_irq_enable && pin_oe == '0 && !port_irq)
    else $error("outputs active after reset");
endmodule // port_pin_io_chk
bind port_pin_io port_pin_io_chk #(.WIDTH(WIDTH), .HV_WIDTH(HV_WIDTH))
  chk_i (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_out,
  .pin_oe, .pin_pull_up, .pin_pull_down, .periph_own, .periph_oe,
  .hv_input_buffer_en, .port_irq, .hv_irq, .ext_irq_enable,
  .signal_routing_select);
`default_nettype wire

// ---- test/pin_partner.sv ----
// External pin model: drivers, pull devices and floating pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] pin_out,
  input  wire logic [WIDTH-1:0] pin_oe,
  input  wire logic [WIDTH-1:0] pin_pull_up,
  input  wire logic [WIDTH-1:0] pin_pull_down,
  input  wire logic [WIDTH-1:0] ext_drive,
  input  wire logic [WIDTH-1:0] ext_level,
  output logic      [WIDTH-1:0] pin_level
);
  logic [WIDTH-1:0] float_q = '0;
  // Undriven unpulled pins wander every cycle
  always_ff @(posedge clk) float_q <= ~pin_level;
  // Resolve each pin from design drive, outside drive and pulls
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (pin_oe[i]) pin_level[i] = pin_out[i];
      else if (ext_drive[i]) pin_level[i] = ext_level[i];
      else if (pin_pull_up[i]) pin_level[i] = 1'b1;
      else if (pin_pull_down[i]) pin_level[i] = 1'b0;
      else pin_level[i] = float_q[i];
    end
  end
endmodule // pin_partner
`default_nettype wire

// ---- test/port_pin_io_tb.sv ----
// Self-checking bench for the general-purpose port block
`timescale 1ns/1ps
`default_nettype none
module port_pin_io_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] rb;
    logic [1:0]  wr;
    logic [1:0]  rr;
    logic        ck;
  } row_t;
  localparam logic [1:0] okay = port_pkg::RESP_OKAY;
  localparam logic [1:0] err = port_pkg::RESP_SLVERR;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        clk_en;
  logic [5:0]  ext_drive;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0]  pin_in, pin_out, pin_oe, pin_reduced_drive, pin_pull_up;
  logic [5:0]  pin_pull_down, periph_own, periph_out, periph_oe, ext_level;
  logic [3:0]  hv_pin_in, hv_input_buffer_en;
  logic        port_irq, hv_irq, ext_irq_enable;
  logic [23:0] signal_routing_select;
  int          error_cnt = 0;
  int          cmp_count = 0;
  row_t rows [15] = '{'{8'h08, 32'h3F, okay, okay, 1'b1},
    '{8'h0C, 32'h3F, okay, okay, 1'b1}, '{8'h10, 32'h3F, okay, okay, 1'b1},
    '{8'h14, 32'h3F, okay, okay, 1'b1}, '{8'h18, 32'h3F, okay, okay, 1'b1},
    '{8'h1C, 32'h3F, okay, okay, 1'b1},
    '{8'h24, 32'h00FF_FFFF, okay, okay, 1'b1},
    '{8'h28, 32'hF, okay, okay, 1'b1}, '{8'h2C, 32'h1, okay, okay, 1'b1},
    '{8'h38, 32'hF, okay, okay, 1'b1}, '{8'h3C, 32'hF, okay, okay, 1'b1},
    '{8'h40, 32'h40, okay, okay, 1'b1}, '{8'h44, 32'h0, err, err, 1'b1},
    '{8'h04, 32'h0, err, okay, 1'b0}, '{8'h30, 32'h0, err, okay, 1'b0}};
  port_pin_io #(.WIDTH(6), .HV_WIDTH(4)) DUT (
    .clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
    .pin_oe, .pin_reduced_drive, .pin_pull_up, .pin_pull_down,
    .periph_own, .periph_out, .periph_oe, .hv_pin_in,
    .hv_input_buffer_en, .port_irq, .hv_irq, .ext_irq_enable,
    .signal_routing_select);
  pin_partner #(.WIDTH(6)) ext_pins (.clk, .pin_out, .pin_oe,
    .pin_pull_up, .pin_pull_down, .ext_drive, .ext_level,
    .pin_level(pin_in));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One write; answer taken when bvalid and bready meet
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge clk);
  endtask
  // One read; ready raised late so the answer must wait
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    rd(a);
    chk(nm, rd_v, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, periph_own, periph_out, periph_oe} = 50'h0;
    {ext_level, hv_pin_in} = 10'h0;
    ext_drive = 6'h3F;
    clk_en = 1'b1;
    cyc(5);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("ext_en", ext_irq_enable, 32'h0);
    rdc("dir rst", 8'h08, 32'h0);
    // Register table: write all ones, read back masked
    foreach (rows[i]) begin
      wr(rows[i].a, 32'hFFFF_FFFF);
      chk("wr resp", rsp, rows[i].wr);
      rd(rows[i].a);
      chk("rd resp", rsp, rows[i].rr);
      if (rows[i].ck) chk("readback", rd_v, rows[i].rb);
    end
    chk("routing", signal_routing_select, 32'h00FF_FFFF);
    chk("ext_en", ext_irq_enable, 32'h1);
    chk("hv buf", hv_input_buffer_en, 32'h0);
    // Read sources with peripheral ownership
    wr(8'h18, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h1C, 32'h0);
    ext_level <= 6'h2A;
    periph_own <= 6'h03;
    periph_oe <= 6'h02;
    periph_out <= 6'h02;
    wr(8'h00, 32'h15);
    wr(8'h08, 32'h05);
    cyc(4);
    chk("oe", pin_oe, 32'h06);
    chk("out", pin_out & pin_oe, 32'h06);
    rdc("input", 8'h04, 32'h2E);
    rdc("data", 8'h00, 32'h2F);
    // Wired-or, pulls and drive strength
    wr(8'h18, 32'h04);
    wr(8'h10, 32'h3F);
    wr(8'h14, 32'h3F);
    ext_drive <= 6'h03; // Outside drivers on pins 2 to 5 let go, pulls decide
    cyc(3);
    chk("wor oe", pin_oe[2], 32'h0);
    chk("pull dn", pin_pull_down & 6'h38, 32'h38);
    chk("wor pull", pin_pull_up[2], 32'h1);
    chk("pp pull", pin_pull_up[1] | pin_pull_down[1], 32'h0);
    chk("reduced", pin_reduced_drive & 6'h06, 32'h06);
    rdc("pulled", 8'h04, 32'h06);
    wr(8'h00, 32'h11);
    wr(8'h14, 32'h0);
    cyc(3);
    chk("wor low", {pin_oe[2], pin_out[2]}, 32'h2);
    chk("pull up", pin_pull_up & 6'h38, 32'h38);
    // Edge flags, filter, masking and clearing
    periph_own <= 6'h0;
    ext_drive <= 6'h3F;
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h01);
    ext_level <= 6'h3E;
    cyc(10);
    wr(8'h20, 32'h3F);
    rdc("flags", 8'h20, 32'h0);
    ext_level <= 6'h01;
    cyc(3);
    ext_level <= 6'h3E;
    cyc(10);
    rdc("glitch", 8'h20, 32'h0);
    ext_level <= 6'h01;
    cyc(12);
    rdc("edge", 8'h20, 32'h3F);
    chk("masked", port_irq, 32'h0);
    wr(8'h1C, 32'h04);
    cyc(3);
    chk("irq", port_irq, 32'h1);
    wr(8'h20, 32'h04);
    cyc(3);
    chk("irq clr", port_irq, 32'h0);
    wr(8'h20, 32'h0);
    rdc("w1c", 8'h20, 32'h3B);
    ext_level <= 6'h3E;
    cyc(12);
    rdc("passive", 8'h20, 32'h3B);
    // High-voltage inputs in digital and analog mode
    wr(8'h3C, 32'h0);
    wr(8'h38, 32'h1);
    wr(8'h28, 32'hF);
    wr(8'h2C, 32'h0);
    hv_pin_in <= 4'hF;
    cyc(10);
    chk("hv dig", hv_input_buffer_en, 32'hF);
    wr(8'h34, 32'hF);
    hv_pin_in <= 4'hA;
    cyc(12);
    rdc("hv in", 8'h30, 32'hA);
    rdc("hv flag", 8'h34, 32'h1);
    chk("hv irq", hv_irq, 32'h1);
    wr(8'h34, 32'h1);
    rdc("hv clr", 8'h34, 32'h0);
    chk("hv irq clr", hv_irq, 32'h0);
    wr(8'h2C, 32'h1);
    cyc(3);
    chk("hv ana", hv_input_buffer_en, 32'h0);
    rdc("hv off", 8'h30, 32'h0);
    // Clock enable low holds every output
    clk_en <= 1'b0;
    periph_own <= 6'h3F;
    periph_oe <= 6'h3F;
    cyc(3);
    chk("frozen oe", pin_oe, 32'h0);
    clk_en <= 1'b1;
    cyc(3);
    chk("run oe", pin_oe, 32'h3F);
    // Reset in mid-run clears outputs and inhibits the external request
    periph_own <= 6'h0;
    periph_oe <= 6'h0;
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("rst oe", pin_oe, 32'h0);
    chk("rst ext", ext_irq_enable, 32'h0);
    rdc("rst route", 8'h24, 32'h0);
    end_of_test();
  end
endmodule // port_pin_io_tb
`default_nettype wire
